// ===== hdl/bccd_pkg.sv
// Purpose: Constants for the start-up clock configuration decoder
// Assumes: One 25 MHz clock, asynchronous active-low reset
// Notes: Field positions of the configuration word and register offsets
package bccd_pkg;
  localparam int CLK_HZ = 25000000;
  localparam logic [3:0] OFS_CFG_WORD = 4'h0;
  localparam logic [3:0] OFS_DECODED = 4'h4;
  localparam logic [3:0] OFS_PB_DIV = 4'h8;
  localparam int POS_SWMON = 14;
  localparam int POS_PBDIV = 12;
  localparam int POS_RSV11 = 11;
  localparam int POS_CLKOUT_DIS = 10;
  localparam int POS_MOSC_MODE = 8;
  localparam int POS_TWO_SPEED = 7;
  localparam int POS_RSV6 = 6;
  localparam int POS_AUX_EN = 5;
  localparam int POS_RSV3 = 3;
  localparam int POS_INIT_OSC = 0;
  localparam logic [31:0] CFG_WORD_RESET = 32'hFFFFFFFF;
  localparam logic [2:0] PB_CNT_RESET = 3'h0;
  typedef enum logic [1:0] {
    BCCD_MOSC_DRIVEN = 2'b00,
    BCCD_MOSC_MEDIUM = 2'b01,
    BCCD_MOSC_HIGH = 2'b10,
    BCCD_MOSC_OFF = 2'b11
  } bccd_mosc_t;
  typedef enum logic [2:0] {
    BCCD_OSC_FAST_RC = 3'b000,
    BCCD_OSC_FRC_DIVN_PLL = 3'b001,
    BCCD_OSC_MAIN = 3'b010,
    BCCD_OSC_MAIN_PLL = 3'b011,
    BCCD_OSC_AUX = 3'b100,
    BCCD_OSC_LOW_POWER_RC = 3'b101,
    BCCD_OSC_FRC_DIV16 = 3'b110,
    BCCD_OSC_FRC_DIVN = 3'b111
  } bccd_osc_t;
endpackage

// ===== hdl/bccd_pb_divider.sv
// Purpose: Peripheral bus clock enable divider (1, 2, 4, 8)
// Assumes: Divisor code is stable after start-up
// Notes: Emits a one-cycle enable pulse per peripheral bus tick
module bccd_pb_divider (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [1:0] pbus_divisor_default,
  output logic pb_tick
);
  logic [2:0] count;
  logic [2:0] next_count;
  logic [2:0] last;
  logic next_tick;

  always_comb begin
    // Four bits so that divide by 8 does not wrap before the subtraction
    last = 3'((4'h1 << pbus_divisor_default) - 4'h1);
    if (count >= last) begin
      next_count = 3'h0;
      next_tick = 1'b1;
    end else begin
      next_count = 3'(count + 3'h1);
      next_tick = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count <= bccd_pkg::PB_CNT_RESET;
      pb_tick <= 1'b0;
    end else begin
      count <= next_count;
      pb_tick <= next_tick;
    end
  end
endmodule

// ===== hdl/bccd_boot_clock_config_decode.sv
// Purpose: Decodes clock fields of the boot configuration word
// Assumes: Configuration word is presented stable around reset release
// Notes: Word captured at first edge after reset release, then held
// Overview of operation
// - Bits 15-14 select switching and fail-safe monitor
// - Bits 13-12 give bus divisor 1,2,4,8
// - Bit 10 clear drives clock out, if mode allows
// - Bits 9-8 select main oscillator mode
// - Bit 7 enables two-speed start-up
// - Bit 5 enables auxiliary crystal oscillator
// - Codes 000-011 select fast RC or main
// - Codes 100-111 select aux, LOW_POWER_RC_OSC, divided RC
module bccd_boot_clock_config_decode (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [31:0] config_word_in,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic clock_switch_enable,
  output logic fail_safe_monitor_enable,
  output logic [1:0] pbus_divisor_default,
  output logic peripheral_bus_clock_en,
  output logic clock_out_function,
  output logic [1:0] main_osc_mode,
  output logic two_speed_startup,
  output logic aux_osc_enable,
  output logic [2:0] initial_osc_choice,
  output logic reserved_bits_ok,
  output logic osc_config_conflict
);
  logic captured;
  logic next_captured;
  logic [31:0] cfg;
  logic [31:0] next_cfg;
  logic [31:0] next_rdata;
  logic next_sw;
  logic next_fsm;
  logic next_clock_out_function;
  logic next_res_ok;
  logic next_conflict;
  logic pb_tick;
  logic [1:0] next_pbdiv;
  logic [1:0] next_mode;
  logic next_two;
  logic next_aux;
  logic [2:0] next_osc;
  logic next_pb_en;

  // Strap capture after release, never under async reset
  always_comb begin
    next_captured = 1'b1;
    next_cfg = captured ? cfg : config_word_in;
  end

  always_comb begin
    next_sw = ~next_cfg[bccd_pkg::POS_SWMON + 1];
    next_fsm = ~next_cfg[bccd_pkg::POS_SWMON + 1] & ~next_cfg[bccd_pkg::POS_SWMON];
    // Clock out only when no crystal uses the pin
    next_clock_out_function = ~next_cfg[bccd_pkg::POS_CLKOUT_DIS] &
      ((next_cfg[bccd_pkg::POS_MOSC_MODE +: 2] == bccd_pkg::BCCD_MOSC_OFF) |
       (next_cfg[bccd_pkg::POS_MOSC_MODE +: 2] == bccd_pkg::BCCD_MOSC_DRIVEN));
    // Flag reserved bits all programmed to one
    next_res_ok = next_cfg[bccd_pkg::POS_RSV11] & next_cfg[bccd_pkg::POS_RSV6] &
      (&next_cfg[bccd_pkg::POS_RSV3 +: 2]);
    // Flag main oscillator off while selected as source
    next_conflict = (next_cfg[bccd_pkg::POS_MOSC_MODE +: 2] == bccd_pkg::BCCD_MOSC_OFF) &&
      ((next_cfg[bccd_pkg::POS_INIT_OSC +: 3] == bccd_pkg::BCCD_OSC_MAIN) ||
       (next_cfg[bccd_pkg::POS_INIT_OSC +: 3] == bccd_pkg::BCCD_OSC_MAIN_PLL));
    next_pbdiv = next_cfg[bccd_pkg::POS_PBDIV +: 2];
    next_mode = next_cfg[bccd_pkg::POS_MOSC_MODE +: 2];
    next_two = next_cfg[bccd_pkg::POS_TWO_SPEED];
    next_aux = next_cfg[bccd_pkg::POS_AUX_EN];
    next_osc = next_cfg[bccd_pkg::POS_INIT_OSC +: 3];
    // Ticks stay off until the divisor code is the captured one
    next_pb_en = pb_tick & captured;
  end

  // Writes are ignored: the word is read-only after start-up
  always_comb begin
    next_rdata = 32'h00000000;
    if (reg_read) begin
      case (reg_addr)
        bccd_pkg::OFS_CFG_WORD: next_rdata = cfg;
        bccd_pkg::OFS_DECODED: next_rdata = {22'h0, osc_config_conflict,
          reserved_bits_ok, clock_out_function, fail_safe_monitor_enable,
          clock_switch_enable, captured, 4'h0};
        bccd_pkg::OFS_PB_DIV: next_rdata = {30'h0, pbus_divisor_default};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      captured <= 1'b0;
      cfg <= bccd_pkg::CFG_WORD_RESET;
      reg_rdata <= 32'h00000000;
      clock_switch_enable <= 1'b0;
      fail_safe_monitor_enable <= 1'b0;
      pbus_divisor_default <= 2'h0;
      clock_out_function <= 1'b0;
      // Main oscillator off until the word is known
      main_osc_mode <= bccd_pkg::BCCD_MOSC_OFF;
      two_speed_startup <= 1'b0;
      aux_osc_enable <= 1'b0;
      initial_osc_choice <= 3'h0;
      reserved_bits_ok <= 1'b0;
      osc_config_conflict <= 1'b0;
      peripheral_bus_clock_en <= 1'b0;
    end else begin
      captured <= next_captured;
      cfg <= next_cfg;
      reg_rdata <= next_rdata;
      clock_switch_enable <= next_sw;
      fail_safe_monitor_enable <= next_fsm;
      pbus_divisor_default <= next_pbdiv;
      clock_out_function <= next_clock_out_function;
      main_osc_mode <= next_mode;
      two_speed_startup <= next_two;
      aux_osc_enable <= next_aux;
      initial_osc_choice <= next_osc;
      reserved_bits_ok <= next_res_ok;
      osc_config_conflict <= next_conflict;
      peripheral_bus_clock_en <= next_pb_en;
    end
  end

  // Bus tick divided from the system clock
  bccd_pb_divider u_pb_div (
    .clock(clock),
    .reset_n(reset_n),
    .pbus_divisor_default(pbus_divisor_default),
    .pb_tick(pb_tick)
  );

  // Decode checks apply from the second edge after release
  chk_swmon_decode: assert property (@(posedge clock) disable iff (!reset_n)
    captured |-> fail_safe_monitor_enable == (cfg[15:14] == 2'b00) &&
      clock_switch_enable == !cfg[15])
    else $error("switch and monitor decode wrong");
  chk_monitor_switch: assert property (@(posedge clock) disable iff (!reset_n)
    fail_safe_monitor_enable |-> clock_switch_enable)
    else $error("monitor on without clock switching");

  chk_pbdiv_field: assert property (@(posedge clock) disable iff (!reset_n)
    captured |-> pbus_divisor_default == cfg[13:12])
    else $error("divisor field wrong");
  chk_pb_tick_div1: assert property (@(posedge clock) disable iff (!reset_n)
    captured && peripheral_bus_clock_en && pbus_divisor_default == 2'b00
    |=> peripheral_bus_clock_en)
    else $error("divide by 1 tick missing");
  chk_pb_tick_div2: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(peripheral_bus_clock_en) && captured && pbus_divisor_default == 2'b01
    |=> !peripheral_bus_clock_en ##1 peripheral_bus_clock_en)
    else $error("divide by 2 spacing wrong");
  chk_pb_tick_div4: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(peripheral_bus_clock_en) && captured && pbus_divisor_default == 2'b10
    |=> !peripheral_bus_clock_en [*3] ##1 peripheral_bus_clock_en)
    else $error("divide by 4 spacing wrong");
  chk_pb_tick_gap: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(peripheral_bus_clock_en) && captured && pbus_divisor_default == 2'b11
    |=> !peripheral_bus_clock_en [*7] ##1 peripheral_bus_clock_en)
    else $error("divide by 8 spacing wrong");
  chk_pb_tick_single: assert property (@(posedge clock) disable iff (!reset_n)
    captured && peripheral_bus_clock_en && pbus_divisor_default != 2'b00
    |=> !peripheral_bus_clock_en)
    else $error("bus tick longer than one cycle");

  chk_reserved_ones: assert property (@(posedge clock) disable iff (!reset_n)
    captured |-> reserved_bits_ok == (cfg[11] && cfg[6] && cfg[4:3] == 2'b11))
    else $error("reserved check wrong");
  chk_clock_out: assert property (@(posedge clock) disable iff (!reset_n)
    captured && (cfg[9:8] == 2'b01 || cfg[9:8] == 2'b10 || cfg[10]) |-> !clock_out_function)
    else $error("clock out enabled wrongly");
  chk_clock_out_on: assert property (@(posedge clock) disable iff (!reset_n)
    captured && !cfg[10] && (cfg[9:8] == 2'b11 || cfg[9:8] == 2'b00)
    |-> clock_out_function)
    else $error("clock out missing");
  chk_mosc_mode: assert property (@(posedge clock) disable iff (!reset_n)
    captured |-> main_osc_mode == cfg[9:8])
    else $error("main osc mode wrong");
  chk_two_speed: assert property (@(posedge clock) disable iff (!reset_n)
    captured |-> two_speed_startup == cfg[7])
    else $error("two-speed wrong");
  chk_aux_enable: assert property (@(posedge clock) disable iff (!reset_n)
    captured |-> aux_osc_enable == cfg[5])
    else $error("aux enable wrong");
  chk_osc_choice: assert property (@(posedge clock) disable iff (!reset_n)
    captured |-> initial_osc_choice == cfg[2:0])
    else $error("osc choice wrong");
  chk_osc_upper: assert property (@(posedge clock) disable iff (!reset_n)
    captured && cfg[2] |-> initial_osc_choice[2] && initial_osc_choice[1:0] == cfg[1:0])
    else $error("upper osc choice wrong");
  chk_conflict_flag: assert property (@(posedge clock) disable iff (!reset_n)
    captured && cfg[9:8] == 2'b11 && cfg[2:1] == 2'b01 |-> osc_config_conflict)
    else $error("conflict not flagged");
  chk_conflict_clear: assert property (@(posedge clock) disable iff (!reset_n)
    captured && !(cfg[9:8] == 2'b11 && cfg[2:1] == 2'b01) |-> !osc_config_conflict)
    else $error("conflict flagged wrongly");

  chk_held_stable: assert property (@(posedge clock) disable iff (!reset_n)
    captured |=> $stable(cfg) && $stable(initial_osc_choice))
    else $error("config changed after capture");
  chk_outputs_held: assert property (@(posedge clock) disable iff (!reset_n)
    captured |=> $stable(main_osc_mode) && $stable(pbus_divisor_default) &&
      $stable(clock_out_function))
    else $error("decoded outputs changed after capture");
  chk_read_word: assert property (@(posedge clock) disable iff (!reset_n)
    captured && reg_read && reg_addr == bccd_pkg::OFS_CFG_WORD |=> reg_rdata == cfg)
    else $error("word readback wrong");

  // Read data stands for one cycle only
  chk_read_idle: assert property (@(posedge clock) disable iff (!reset_n)
    !reg_read |=> reg_rdata == 32'h00000000)
    else $error("read data without a read");
  chk_read_unmapped: assert property (@(posedge clock) disable iff (!reset_n)
    reg_read && reg_addr != bccd_pkg::OFS_CFG_WORD && reg_addr != bccd_pkg::OFS_DECODED &&
      reg_addr != bccd_pkg::OFS_PB_DIV |=> reg_rdata == 32'h00000000)
    else $error("unmapped read not zero");
endmodule

// ===== sim/tb_boot_clock_config_decode.sv
// Purpose: Self-checking bench for the start-up clock configuration decoder
// Assumes: Word is strapped before reset release and read back over the register port
// Notes: Eight table-built words sweep every field code, one reset each
module tb_boot_clock_config_decode;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic [31:0] config_word_in = 32'h0, reg_wdata = 32'h0, reg_rdata, rd;
  logic [3:0] reg_addr = 4'h0;
  logic sw, mon, pbce, co, two, aux, rok, conf;
  logic [1:0] pbd, mode;
  logic [2:0] osc;
  int fail_count = 0, n_tests = 0;
  always #20 clock = ~clock;
  bccd_boot_clock_config_decode dut (.clock(clock), .reset_n(reset_n),
    .config_word_in(config_word_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .clock_switch_enable(sw), .fail_safe_monitor_enable(mon), .pbus_divisor_default(pbd),
    .peripheral_bus_clock_en(pbce), .clock_out_function(co), .main_osc_mode(mode),
    .two_speed_startup(two), .aux_osc_enable(aux), .initial_osc_choice(osc),
    .reserved_bits_ok(rok), .osc_config_conflict(conf));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask
  task automatic results();
    if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task automatic boot(input logic [31:0] w);
    @(posedge clock);
    reset_n <= 1'b0;
    config_word_in <= w;
    repeat (6) @(posedge clock);
    #1 chk(mode, 2'b11, "reset mode");
    @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic check_decode(input logic [31:0] w);
    chk(sw, !w[15], "switch enable");
    chk(mon, w[15:14] == 2'b00, "monitor enable");
    chk(pbd, w[13:12], "divisor code");
    chk(co, !w[10] && (w[9:8] == 2'b11 || w[9:8] == 2'b00), "clock out");
    chk(mode, w[9:8], "osc mode");
    chk(two, w[7], "two speed");
    chk(aux, w[5], "aux osc");
    chk(osc, w[2:0], "initial osc");
    chk(rok, w[11] & w[6] & w[4] & w[3], "reserved flag");
    chk(conf, w[9:8] == 2'b11 && w[2:1] == 2'b01, "conflict flag");
  endtask
  task automatic check_divider(input logic [1:0] c);
    int k, n;
    k = 0;
    n = 0;
    while (k < 20 && pbce !== 1'b1) begin
      @(posedge clock);
      #1 k++;
    end
    do begin
      @(posedge clock);
      #1 n++;
    end while (n < 20 && pbce !== 1'b1);
    chk(n, 32'h1 << c, "bus tick spacing");
  endtask
  task automatic check_regs(input logic [31:0] w);
    rd_reg(4'h0);
    chk(rd, w, "word readback");
    rd_reg(4'h4);
    chk(rd, {22'h0, w[9:8] == 2'b11 && w[2:1] == 2'b01, w[11] & w[6] & w[4] & w[3],
      !w[10] && (w[9:8] == 2'b11 || w[9:8] == 2'b00), w[15:14] == 2'b00, !w[15], 1'b1, 4'h0},
      "status readback");
    rd_reg(4'h8);
    chk(rd, {30'h0, w[13:12]}, "divisor readback");
    rd_reg(4'hC);
    chk(rd, 32'h0, "unmapped read");
    @(posedge clock);
    #1 chk(reg_rdata, 32'h0, "read data stood too long");
  endtask
  task automatic check_hold(input logic [31:0] w);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= 4'h0;
    reg_wdata <= ~w;
    config_word_in <= ~w;
    @(posedge clock);
    reg_write <= 1'b0;
    repeat (3) @(posedge clock);
    #1 check_decode(w);
    rd_reg(4'h0);
    chk(rd, w, "word held");
  endtask
  initial begin
    logic [31:0] w;
    for (int i = 0; i < 8; i++) begin
      w = {16'hA5C3, i[1:0], i[1:0], 1'b1, i[2], i[1], ~i[0], i[0], i != 5, ~i[0], 2'b11,
        i[2:0]};
      boot(w);
      check_decode(w);
      check_divider(w[13:12]);
      check_regs(w);
      check_hold(w);
    end
    results();
  end
  // Sweep needs under 300 cycles; generous margin before calling it hung
  initial begin
    #400000;
    fail_count++;
    results();
  end
endmodule
